// ### shared/arcs_cfg.svh
// constants for the result checksum and status block
// Operation
// - supply and regulator channels convert when channel register holds their identifier
// - software mode lets diagnostic channels sit in sequencer steps
// - self-test channel returns 0xAAAA for A and 0x5555 for B; code switches both results on the A-side select only
// - checksum works in software mode, or hardware serial; never hardware parallel
// - checksum enable and status word enable always act together
// - hardware mode samples checksum pin at full reset release, fixed afterwards
// - appended word: upper byte channel ids, lower byte checksum
// - status word comes on one extra read after the results, and on a register read of address 0x08
// - software mode: either checksum bit or status bit enables checksum
// - checksum covers A and B results, sent after them
// - checksum starts at zero per sequence, A first then B, chained
// - next bit 0 equation
// - next bit 1 equation
// - next bit 2 equation
// - next bit 3 equation
// - next bit 4 equation
// - next bit 5 equation
// - next bit 6 equation, garbled operator taken as XOR
// - next bit 7 equation
// - reset loads steps 0..7 with pairs 0..7, other 24 steps zero
// - status word: A id 15:12, B id 11:8, checksum 7:0
// - command word: write flag 15, address 14:9, data 8:0
`ifndef ARCS_CFG_SVH
`define ARCS_CFG_SVH
`define ARCS_ADDR_CONFIG    6'h02
`define ARCS_ADDR_CHANNEL   6'h03
`define ARCS_ADDR_RANGE_AL  6'h04
`define ARCS_ADDR_RANGE_AH  6'h05
`define ARCS_ADDR_RANGE_BL  6'h06
`define ARCS_ADDR_RANGE_BH  6'h07
`define ARCS_ADDR_STATUS    6'h08
`define ARCS_ADDR_RESULT    6'h00
`define ARCS_STACK_BIT      5
`define ARCS_RANGE_RESET    9'h0ff
`define ARCS_CMD_WR_BIT     15
`define ARCS_BIT_CHECKSUM_ON      0
`define ARCS_BIT_STATEN     1
`define ARCS_BIT_SEQUENCER_ON      5
`define ARCS_BIT_BURST      6
`define ARCS_BIT_SELF_DETECT_ERROR_FLAG       7
`define ARCS_BIT_LAST       8
`define ARCS_CH_VCC         4'h8
`define ARCS_CH_LDO         4'h9
`define ARCS_CH_SELFTEST    4'hb
`define ARCS_SELF_A         16'haaaa
`define ARCS_SELF_B         16'h5555
`define ARCS_DIAG_MAX_KSPS  250
`define ARCS_STEPS          32
`define ARCS_INIT_STEPS     8
`endif

// ### shared/arcs_pkg.sv
// types for the result checksum and status block
package arcs_pkg;
  // one register command word
  typedef struct packed {
    logic       wr;
    logic [5:0] addr;
    logic [8:0] data;
  } arcs_cmd_s;
  // one converted pair from the converter core
  typedef struct packed {
    logic [3:0]  a_side_channel_select;
    logic [3:0]  b_side_channel_select;
    logic [15:0] resA;
    logic [15:0] resB;
    logic        seqStart;
  } arcs_pair_s;
  // readback state of the result port
  typedef enum logic [1:0] {ST_IDLE, ST_RES_A, ST_RES_B, ST_STATUS} arcs_rd_e;
endpackage

// ### src/arcs_crc_step.sv
// one chained checksum update over a 16-bit result
`timescale 1ns/1ps
module arcs_crc_step
(
  // data and running value
  input  wire logic [15:0] data,
  input  wire logic [7:0]  crcIn,
  // updated value
  output logic      [7:0]  crcOut
);
  import arcs_pkg::*;

  // single-cycle xor network
  always_comb
  begin
    crcOut[0] = data[14] ^ data[12] ^ data[8] ^ data[7] ^ data[6] ^ data[0]
              ^ crcIn[0] ^ crcIn[4] ^ crcIn[6];
    crcOut[1] = data[15] ^ data[14] ^ data[13] ^ data[12] ^ data[9] ^ data[6]
              ^ data[1] ^ data[0] ^ crcIn[1] ^ crcIn[4] ^ crcIn[5] ^ crcIn[6] ^ crcIn[7];
    crcOut[2] = data[15] ^ data[13] ^ data[12] ^ data[10] ^ data[8] ^ data[6]
              ^ data[2] ^ data[1] ^ data[0] ^ crcIn[0] ^ crcIn[2] ^ crcIn[4]
              ^ crcIn[5] ^ crcIn[7];
    crcOut[3] = data[14] ^ data[13] ^ data[11] ^ data[9] ^ data[7] ^ data[3]
              ^ data[2] ^ data[1] ^ crcIn[1] ^ crcIn[3] ^ crcIn[5] ^ crcIn[6];
    crcOut[4] = data[15] ^ data[14] ^ data[12] ^ data[10] ^ data[8] ^ data[4]
              ^ data[3] ^ data[2] ^ crcIn[0] ^ crcIn[2] ^ crcIn[4] ^ crcIn[6] ^ crcIn[7];
    crcOut[5] = data[15] ^ data[13] ^ data[11] ^ data[9] ^ data[5] ^ data[4]
              ^ data[3] ^ crcIn[1] ^ crcIn[3] ^ crcIn[5] ^ crcIn[7];
    crcOut[6] = data[14] ^ data[12] ^ data[10] ^ data[6] ^ data[5] ^ data[4]
              ^ crcIn[2] ^ crcIn[4] ^ crcIn[6];
    crcOut[7] = data[15] ^ data[13] ^ data[11] ^ data[7] ^ data[6] ^ data[5]
              ^ crcIn[3] ^ crcIn[5] ^ crcIn[7];
  end
endmodule

// ### src/arcs_result_crc.sv
// result checksum, status word, self test and register file
`timescale 1ns/1ps
`include "arcs_cfg.svh"
module arcs_result_crc
(
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_b,
  // straps and pins
  input  wire logic                 hwMode,
  input  wire logic                 serialMode,
  input  wire logic                 checksumOnPin,
  input  wire logic                 partialReset,
  input  wire logic                 selfDetectErr,
  // register command port
  input  wire logic                 cmdValid,
  input  wire arcs_pkg::arcs_cmd_s  cmd,
  // converter pairs in
  input  wire logic                 pairValid,
  output logic                      pairReady,
  input  wire arcs_pkg::arcs_pair_s pair,
  // result read port
  input  wire logic                 rdReq,
  output logic                      rdValid,
  output logic [15:0]               rdData,
  // control out to the converter
  output logic [3:0]                aSideChannelSelect,
  output logic [3:0]                bSideChannelSelect,
  output logic                      sequencerOn,
  output logic                      burstEnableBit,
  output logic                      checksumActive
);
  import arcs_pkg::*;

  //----------------------------------------
  // reset release and strap capture
  //----------------------------------------
  logic [1:0] rstSync_q;
  logic       rstN;
  logic       strapDone_q;
  logic       pinCrc_q;
  logic [2:0] pinSync_q;

  // two-flop reset release
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b) rstSync_q <= 2'b00;
    else        rstSync_q <= {rstSync_q[0], 1'b1};
  end
  assign rstN = rstSync_q[1];

  // pin filter, free running so the strap has settled by the time reset lets go
  always_ff @(posedge core_clk)
  begin
    pinSync_q <= {pinSync_q[1:0], checksumOnPin};
  end

  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      strapDone_q <= 1'b0;
      pinCrc_q    <= 1'b0;
    end
    // a level counts only once the last two filter stages agree
    else if (!strapDone_q && (pinSync_q[2] == pinSync_q[1]))
    begin
      strapDone_q <= 1'b1;
      pinCrc_q    <= pinSync_q[2];
    end
  end

  //----------------------------------------
  // registers
  //----------------------------------------
  logic [8:0] config_q;
  logic [7:0] chanSel_q;
  logic [8:0] range_q [4];
  logic [8:0] stack_q [`ARCS_STEPS];
  logic       rdPendReg_q;
  logic [5:0] rdAddr_q;
  logic       cmdWr;

  assign cmdWr = cmdValid && cmd.wr;

  // configuration, channel and range
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      config_q  <= 9'h000;
      chanSel_q <= 8'h00;
      for (int i = 0; i < 4; i++) range_q[i] <= `ARCS_RANGE_RESET;
    end
    // write flag, address, nine data bits
    else if (cmdWr && !cmd.addr[`ARCS_STACK_BIT])
    begin
      if (cmd.addr == `ARCS_ADDR_CONFIG)
        config_q <= cmd.data;
      else if (cmd.addr == `ARCS_ADDR_CHANNEL)
        chanSel_q <= cmd.data[7:0];
      else if (cmd.addr >= `ARCS_ADDR_RANGE_AL && cmd.addr <= `ARCS_ADDR_RANGE_BH)
        range_q[cmd.addr[1:0]] <= cmd.data;
    end
  end

  // sequencer steps reload on full or partial reset
  // steps may hold diagnostic ids; no check made
  genvar g;
  generate
    for (g = 0; g < `ARCS_STEPS; g++)
    begin : gStep
      always_ff @(posedge core_clk or negedge rstN)
      begin
        if (!rstN)
          stack_q[g] <= (g < `ARCS_INIT_STEPS) ? 9'((g << 4) | g) : 9'h000;
        else if (partialReset)
          stack_q[g] <= (g < `ARCS_INIT_STEPS) ? 9'((g << 4) | g) : 9'h000;
        else if (cmdWr && cmd.addr == {1'b1, 5'(g)})
          stack_q[g] <= cmd.data;
      end
    end
  endgenerate

  // read request remembered for next read
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      rdPendReg_q <= 1'b0;
      rdAddr_q    <= 6'h00;
    end
    else if (cmdValid && !cmd.wr)
    begin
      rdPendReg_q <= (cmd.addr != `ARCS_ADDR_RESULT);
      rdAddr_q    <= cmd.addr;
    end
    else if (rdReq && rdPendReg_q)
      rdPendReg_q <= 1'b0;
  end

  //----------------------------------------
  // checksum enable
  //----------------------------------------
  logic checksum_on;
  assign checksum_on = hwMode ? (pinCrc_q && serialMode && strapDone_q)
                        : (config_q[`ARCS_BIT_CHECKSUM_ON] || config_q[`ARCS_BIT_STATEN]);

  //----------------------------------------
  // two-entry pair buffer
  //----------------------------------------
  arcs_pair_s buf_q [2];
  logic [1:0] bufCnt_q;
  logic [1:0] bufCntNext;
  logic       bufRd_q;
  logic       bufWr_q;
  logic       take;
  logic       pop;

  assign take = pairValid && pairReady;
  assign bufCntNext = 2'(bufCnt_q + 2'(take) - 2'(pop));

  // buffer storage and pointers
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      bufCnt_q <= 2'd0;
      pairReady <= 1'b0;
      bufRd_q  <= 1'b0;
      bufWr_q  <= 1'b0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end
    else
    begin
      if (take)
      begin
        buf_q[bufWr_q] <= pair;
        bufWr_q        <= ~bufWr_q;
      end
      if (pop) bufRd_q <= ~bufRd_q;
      bufCnt_q <= bufCntNext;
      pairReady <= (bufCntNext != 2'd2); // registered so the output comes from a flop
    end
  end

  //----------------------------------------
  // readback sequence and checksum
  //----------------------------------------
  arcs_rd_e   rdState_q;
  arcs_pair_s cur_q;
  arcs_pair_s head;
  logic [15:0] resA;
  logic [15:0] resB;
  logic [7:0]  crc_q;
  logic [7:0]  crcBase;
  logic [7:0]  crcA;
  logic [7:0]  crcB;
  logic [7:0]  statId_q;
  logic [7:0]  statCrc_q;
  logic        selfTest;

  assign head     = buf_q[bufRd_q];
  assign pop      = (rdState_q == ST_IDLE) && (bufCnt_q != 2'd0);
  assign selfTest = (chanSel_q[3:0] == `ARCS_CH_SELFTEST);
  assign resA     = selfTest ? `ARCS_SELF_A : cur_q.resA;
  assign resB     = selfTest ? `ARCS_SELF_B : cur_q.resB;
  // start at zero for each sequence
  assign crcBase  = cur_q.seqStart ? 8'h00 : crc_q;

  // one network per word, A then B
  arcs_crc_step uCrcA
  (
    .data  (resA),
    .crcIn (crcBase),
    .crcOut(crcA)
  );
  arcs_crc_step uCrcB
  (
    .data  (resB),
    .crcIn (crcA),
    .crcOut(crcB)
  );

  // read state machine
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      rdState_q <= ST_IDLE;
      cur_q     <= '0;
      crc_q     <= 8'h00;
      statId_q  <= 8'h00;
      statCrc_q <= 8'h00;
    end
    else
    begin
      case (rdState_q)
        ST_IDLE:
          if (pop)
          begin
            cur_q     <= head;
            rdState_q <= ST_RES_A;
          end
        ST_RES_A:
          if (rdReq && !rdPendReg_q) rdState_q <= ST_RES_B;
        ST_RES_B:
          if (rdReq && !rdPendReg_q)
          begin
            // chained value kept after B is sent
            crc_q     <= crcB;
            statId_q  <= {cur_q.a_side_channel_select, cur_q.b_side_channel_select};
            statCrc_q <= crcB;
            rdState_q <= checksum_on ? ST_STATUS : ST_IDLE;
          end
        ST_STATUS:
          if (rdReq && !rdPendReg_q) rdState_q <= ST_IDLE;
        default:
          rdState_q <= ST_IDLE;
      endcase
    end
  end

  //----------------------------------------
  // read data mux and outputs
  //----------------------------------------
  logic [15:0] regData;

  // register readback, address decode
  always_comb
  begin
    regData = 16'h0000;
    if (rdAddr_q[`ARCS_STACK_BIT])
      regData = {1'b0, rdAddr_q, stack_q[rdAddr_q[4:0]]};
    else if (rdAddr_q == `ARCS_ADDR_CONFIG)
      regData = {1'b0, rdAddr_q, 1'b0, selfDetectErr, config_q[6:0]};
    else if (rdAddr_q == `ARCS_ADDR_CHANNEL)
      regData = {1'b0, rdAddr_q, 1'b0, chanSel_q};
    else if (rdAddr_q >= `ARCS_ADDR_RANGE_AL && rdAddr_q <= `ARCS_ADDR_RANGE_BH)
      regData = {1'b0, rdAddr_q, 1'b0, range_q[rdAddr_q[1:0]][7:0]};
    else if (rdAddr_q == `ARCS_ADDR_STATUS)
      regData = {statId_q, statCrc_q};
  end

  // registered read answer
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      rdValid <= 1'b0;
      rdData  <= 16'h0000;
    end
    else
    begin
      rdValid <= 1'b0;
      if (rdReq && rdPendReg_q)
      begin
        rdValid <= 1'b1;
        rdData  <= regData;
      end
      else if (rdReq && rdState_q != ST_IDLE)
      begin
        rdValid <= 1'b1;
        // ids high byte, checksum low byte
        rdData  <= (rdState_q == ST_RES_A) ? resA :
                   (rdState_q == ST_RES_B) ? resB : {statId_q, statCrc_q}; // statCrc_q holds the same value as crc_q
      end
    end
  end

  // channel selection drives converter mux, diag ids included
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      aSideChannelSelect <= 4'h0;
      bSideChannelSelect <= 4'h0;
      sequencerOn        <= 1'b0;
      burstEnableBit     <= 1'b0;
      checksumActive     <= 1'b0;
    end
    else
    begin
      aSideChannelSelect <= chanSel_q[3:0];
      bSideChannelSelect <= chanSel_q[7:4];
      sequencerOn        <= config_q[`ARCS_BIT_SEQUENCER_ON];
      burstEnableBit     <= config_q[`ARCS_BIT_BURST];
      checksumActive     <= checksum_on;
    end
  end

  //----------------------------------------
  // checks
  //----------------------------------------
  AST_SELFTEST_A: assert property (@(posedge core_clk) disable iff (!rstN)
    (rdReq && !rdPendReg_q && rdState_q == ST_RES_A && selfTest)
      |=> (rdValid && rdData == `ARCS_SELF_A))
    else $error("self test A code wrong");
  AST_SELFTEST_B: assert property (@(posedge core_clk) disable iff (!rstN)
    (rdReq && !rdPendReg_q && rdState_q == ST_RES_B && selfTest)
      |=> (rdValid && rdData == `ARCS_SELF_B))
    else $error("self test B code wrong");
  AST_NO_HW_PAR: assert property (@(posedge core_clk) disable iff (!rstN)
    (hwMode && !serialMode) |-> !checksum_on)
    else $error("checksum on in hardware parallel mode");
  AST_SW_ENABLE: assert property (@(posedge core_clk) disable iff (!rstN)
    (!hwMode && (config_q[`ARCS_BIT_CHECKSUM_ON] || config_q[`ARCS_BIT_STATEN])) |-> checksum_on)
    else $error("software enable ignored");
  AST_STRAP_HOLD: assert property (@(posedge core_clk) disable iff (!rstN)
    strapDone_q |=> $stable(pinCrc_q))
    else $error("strap changed after release");
  AST_STATUS_READ: assert property (@(posedge core_clk) disable iff (!rstN)
    (rdReq && !rdPendReg_q && rdState_q == ST_RES_B && !checksum_on) |=> rdState_q == ST_IDLE)
    else $error("status read without enable");
  AST_SEQ_ZERO: assert property (@(posedge core_clk) disable iff (!rstN)
    (rdState_q == ST_RES_B && cur_q.seqStart) |-> crcBase == 8'h00)
    else $error("checksum not cleared at sequence start");
  AST_STATUS_WORD: assert property (@(posedge core_clk) disable iff (!rstN)
    (rdReq && !rdPendReg_q && rdState_q == ST_STATUS)
      |=> (rdValid && rdData == {statId_q, statCrc_q}))
    else $error("status word layout wrong");
  AST_STACK_INIT: assert property (@(posedge core_clk) disable iff (!rstN)
    partialReset |=> (stack_q[1] == 9'h011 && stack_q[8] == 9'h000))
    else $error("stack not reinitialised");
endmodule

// ### dv/arcs_host_model.sv
// host controller model: reads results and rechecks the pair checksum
`timescale 1ns/1ps
module arcs_host_model
(
  // clock
  input  wire logic        core_clk,
  // result read port
  input  wire logic        rdValid,
  input  wire logic [15:0] rdData,
  output logic             rdReq
);
  logic [7:0] crcRun;

  // idle until the bench asks for a read
  initial
  begin
    rdReq = 1'b0;
    crcRun = 8'h00;
  end

  function automatic logic [7:0] crcStep(input logic [15:0] d, input logic [7:0] c);
    logic [7:0] n;
    n[0] = d[14]^d[12]^d[8]^d[7]^d[6]^d[0]^c[0]^c[4]^c[6];
    n[1] = d[15]^d[14]^d[13]^d[12]^d[9]^d[6]^d[1]^d[0]^c[1]^c[4]^c[5]^c[6]^c[7];
    n[2] = d[15]^d[13]^d[12]^d[10]^d[8]^d[6]^d[2]^d[1]^d[0]^c[0]^c[2]^c[4]^c[5]^c[7];
    n[3] = d[14]^d[13]^d[11]^d[9]^d[7]^d[3]^d[2]^d[1]^c[1]^c[3]^c[5]^c[6];
    n[4] = d[15]^d[14]^d[12]^d[10]^d[8]^d[4]^d[3]^d[2]^c[0]^c[2]^c[4]^c[6]^c[7];
    n[5] = d[15]^d[13]^d[11]^d[9]^d[5]^d[4]^d[3]^c[1]^c[3]^c[5]^c[7];
    n[6] = d[14]^d[12]^d[10]^d[6]^d[5]^d[4]^c[2]^c[4]^c[6];
    n[7] = d[15]^d[13]^d[11]^d[7]^d[6]^d[5]^c[3]^c[5]^c[7];
    return n;
  endfunction

  // new sequence, so the running value restarts at zero
  task clearRun;
    crcRun = 8'h00;
  endtask

  // one pulse request; answer is looked at in the cycle after it is taken
  task automatic readWord(output logic [15:0] d, output logic got);
    @(posedge core_clk);
    rdReq <= 1'b1;
    @(posedge core_clk);
    rdReq <= 1'b0;
    @(negedge core_clk);
    got = (rdValid === 1'b1);
    d = rdData;
  endtask

  // status word needs its own extra read
  task automatic readPair(output logic [15:0] a, b, s, output logic ok);
    logic ga, gb, gs;
    readWord(a, ga);
    readWord(b, gb);
    readWord(s, gs);
    // recompute over what was received, A before B
    crcRun = crcStep(b, crcStep(a, crcRun));
    ok = ga & gb & gs & (s[7:0] === crcRun);
  endtask
endmodule

// ### dv/arcs_result_crc_tb_top.sv
// self-checking bench for the result checksum and status block
`timescale 1ns/1ps
`include "arcs_cfg.svh"
module arcs_result_crc_tb_top;
  import arcs_pkg::*;
  logic        core_clk, rst_b, hwMode, serialMode, checksumOnPin;
  logic        partialReset, selfDetectErr, cmdValid, pairValid, pairReady;
  logic        rdReq, rdValid, seqOn, burstOn, ckActive, ok;
  arcs_cmd_s   cmd;
  arcs_pair_s  pair;
  logic [15:0] rdData, rA, rB, rS;
  logic [3:0]  aSel, bSel;
  int          n_mismatch, tests_run, i, k, nAcc;

  arcs_result_crc dut (.core_clk(core_clk), .rst_b(rst_b), .hwMode(hwMode),
    .serialMode(serialMode), .checksumOnPin(checksumOnPin), .partialReset(partialReset),
    .selfDetectErr(selfDetectErr), .cmdValid(cmdValid), .cmd(cmd), .pairValid(pairValid),
    .pairReady(pairReady), .pair(pair), .rdReq(rdReq), .rdValid(rdValid), .rdData(rdData),
    .aSideChannelSelect(aSel), .bSideChannelSelect(bSel), .sequencerOn(seqOn),
    .burstEnableBit(burstOn), .checksumActive(ckActive));

  arcs_host_model host (.core_clk(core_clk), .rdValid(rdValid), .rdData(rdData),
    .rdReq(rdReq));

  // free-running core clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task give_verdict;
    $display("checks made %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // straps settle while reset is held; commands wait for the internal release
  task fullReset(input logic hw, input logic ser, input logic pin);
    @(posedge core_clk);
    rst_b <= 1'b0;
    hwMode <= hw;
    serialMode <= ser;
    checksumOnPin <= pin;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge core_clk);
  endtask

  task sendCmd(input logic w, input logic [5:0] a, input logic [8:0] d);
    @(posedge core_clk);
    cmdValid <= 1'b1;
    cmd <= '{wr: w, addr: a, data: d};
    @(posedge core_clk);
    cmdValid <= 1'b0;
  endtask

  task regRead(input logic [5:0] a, input logic [8:0] exp, input string what);
    logic [15:0] d;
    logic        got;
    sendCmd(1'b0, a, 9'h000);
    host.readWord(d, got);
    check(what, {6'h00, got, d[8:0]}, {6'h00, 1'b1, exp});
  endtask

  // a pair is offered for a few cycles; a full buffer refuses it
  task sendPair(input arcs_pair_s p, output logic taken);
    int n;
    @(posedge core_clk);
    pairValid <= 1'b1;
    pair <= p;
    taken = 1'b0;
    for (n = 0; n < 4 && !taken; n++)
    begin
      @(negedge core_clk);
      taken = (pairReady === 1'b1);
      @(posedge core_clk);
    end
    pairValid <= 1'b0;
  endtask

  task readPairChk(input logic [15:0] eA, input logic [15:0] eB, input logic [7:0] ids);
    host.readPair(rA, rB, rS, ok);
    check("result A", rA, eA);
    check("result B", rB, eB);
    check("status ids", {8'h00, rS[15:8]}, {8'h00, ids});
    check("status checksum", {15'h0000, ok}, 16'h0001);
  endtask

  function automatic arcs_pair_s mk(input int n, input logic st);
    return '{a_side_channel_select: 4'(n), b_side_channel_select: 4'(n + 5), resA: 16'h8001 + 16'(n) * 16'h0123,
             resB: 16'h7ffe - 16'(n) * 16'h0457, seqStart: st};
  endfunction

  // watchdog far beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    n_mismatch++;
    give_verdict;
  end

  initial
  begin
    {hwMode, serialMode, checksumOnPin, partialReset, cmdValid, pairValid} = 6'h00;
    rst_b = 1'b0;
    selfDetectErr = 1'b1;
    cmd = '0;
    pair = '0;
    fullReset(1'b0, 1'b0, 1'b0);
    regRead(`ARCS_ADDR_CONFIG, 9'h080, "config reset");
    regRead(`ARCS_ADDR_CHANNEL, 9'h000, "channel reset");
    for (i = 0; i < 4; i++)
      regRead(`ARCS_ADDR_RANGE_AL + 6'(i), `ARCS_RANGE_RESET, "range reset");
    for (i = 0; i < 32; i++)
      regRead(6'h20 | 6'(i), i < 8 ? {1'b0, 4'(i), 4'(i)} : 9'h000, "step reset");
    $display("test register reset values done");
    sendCmd(1'b1, 6'h21, 9'h1ff);
    regRead(6'h21, 9'h1ff, "step written");
    @(posedge core_clk);
    partialReset <= 1'b1;
    @(posedge core_clk);
    partialReset <= 1'b0;
    regRead(6'h21, 9'h011, "step reloaded");
    $display("test partial reset done");
    for (i = 0; i < 2; i++)
    begin
      sendCmd(1'b1, `ARCS_ADDR_CHANNEL, i == 0 ? 9'h098 : 9'h089);
      repeat (2) @(posedge core_clk);
      check("a side select", {12'h000, aSel}, i == 0 ? 16'h0008 : 16'h0009);
      check("b side select", {12'h000, bSel}, i == 0 ? 16'h0009 : 16'h0008);
    end
    sendCmd(1'b1, 6'h0a, 9'h1ff);
    regRead(`ARCS_ADDR_CHANNEL, 9'h089, "channel kept");
    $display("test diagnostic select done");
    sendCmd(1'b1, `ARCS_ADDR_CONFIG, 9'h000);
    sendPair(mk(1, 1'b1), ok);
    repeat (3) @(posedge core_clk);
    host.readWord(rA, ok);
    host.readWord(rB, ok);
    host.readWord(rS, ok);
    check("no status when off", {15'h0000, ok}, 16'h0000);
    check("checksum off", {15'h0000, ckActive}, 16'h0000);
    for (i = 0; i < 2; i++)
    begin
      serialMode <= i[0];
      sendCmd(1'b1, `ARCS_ADDR_CONFIG, i == 0 ? 9'h001 : 9'h002);
      repeat (2) @(posedge core_clk);
      check("checksum on", {15'h0000, ckActive}, 16'h0001);
      host.clearRun();
      for (k = 0; k < 3; k++)
      begin
        sendPair(mk(k + i, k == 0), ok);
        repeat (3) @(posedge core_clk);
        readPairChk(mk(k + i, 1'b0).resA, mk(k + i, 1'b0).resB,
                    {4'(k + i), 4'(k + i + 5)});
      end
    end
    regRead(`ARCS_ADDR_CONFIG, 9'h082, "config written");
    $display("test chained checksum done");
    sendCmd(1'b1, `ARCS_ADDR_CHANNEL, 9'h0bb);
    host.clearRun();
    sendPair('{a_side_channel_select: 4'hb, b_side_channel_select: 4'hb, resA: 16'h1357, resB: 16'h2468, seqStart: 1'b1}, ok);
    repeat (3) @(posedge core_clk);
    readPairChk(`ARCS_SELF_A, `ARCS_SELF_B, 8'hbb);
    $display("test self test done");
    sendCmd(1'b1, `ARCS_ADDR_CHANNEL, 9'h000);
    host.clearRun();
    nAcc = 0;
    for (k = 0; k < 6 && (k == nAcc); k++)
    begin
      sendPair(mk(k, k == 0), ok);
      if (ok === 1'b1)
        nAcc++;
    end
    check("pairs taken before stall", {12'h000, 4'(nAcc)}, 16'h0003);
    for (k = 0; k < nAcc; k++)
      readPairChk(mk(k, 1'b0).resA, mk(k, 1'b0).resB, {4'(k), 4'(k + 5)});
    $display("test buffer stall done");
    fullReset(1'b1, 1'b1, 1'b1);
    check("hw serial strap", {15'h0000, ckActive}, 16'h0001);
    checksumOnPin <= 1'b0;
    host.clearRun();
    sendPair(mk(3, 1'b1), ok);
    repeat (3) @(posedge core_clk);
    readPairChk(mk(3, 1'b0).resA, mk(3, 1'b0).resB, 8'h38);
    check("strap held", {15'h0000, ckActive}, 16'h0001);
    fullReset(1'b1, 1'b1, 1'b0);
    check("hw strap low", {15'h0000, ckActive}, 16'h0000);
    fullReset(1'b1, 1'b0, 1'b1);
    check("hw parallel", {15'h0000, ckActive}, 16'h0000);
    $display("test hardware mode done");
    give_verdict;
  end
endmodule
